//--- core/tsc_defs.svh
`ifndef TSC_DEFS_SVH
`define TSC_DEFS_SVH
`define TSC_CLK_MHZ 25
`define TSC_CONV12_US 10
`define TSC_CONV8_US 7
`define TSC_CONV12_CYC (`TSC_CONV12_US * `TSC_CLK_MHZ)
`define TSC_CONV8_CYC (`TSC_CONV8_US * `TSC_CLK_MHZ)
`define TSC_HS_CODE 5'h01
`define TSC_CMD_MODE_BIT 1
`define TSC_CMD_PD0_BIT 2
`define TSC_CMD_PD1_BIT 3
`define TSC_CMD_CFG_LSB 4
`define TSC_ADDR_RST 7'h48
`endif

//--- core/tsc_pkg.sv
package tsc_pkg;
    typedef struct packed {
        logic [3:0] input_config_code;
        logic refer_powerdown_bit;
        logic driver_powerdown_bit;
        logic mode_8bit;
    } tsc_cmd_t;
    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_ADDR = 7'b0000010,
        ST_AACK = 7'b0000100,
        ST_CMD = 7'b0001000,
        ST_CACK = 7'b0010000,
        ST_TX = 7'b0100000,
        ST_MACK = 7'b1000000
    } tsc_state_t;
endpackage

//--- core/tsc_ctrl.sv
// Functional notes
// - Master sends 00001xxx after Start; device does not ack, enters high-speed.
// - High-speed persists across repeated Starts until a Stop.
// - Read before conversion end: hold SCL low until result latched.
// - Results are unsigned straight binary codes.
// - Mode bit set: 8-bit conversion, whole result in one byte.
// - 8-bit conversion is four bit steps shorter than 12-bit.
// - Powered down with driver bit clear: pen path armed to X-plus.
// - Armed and touched: pen interrupt output driven low.
// - X, Y, Z measurements disconnect pen pulldown path.
// - Driver-only commands disable detection and force pen output low.
// - Last command with driver bit set keeps pen detection disabled.
// - Pen interrupt disabled on write-address acknowledge.
// - Driver bit clear: re-enable at conversion end, 10 or 7 us after.
// - 12-bit read: bits 11..4, then bits 3..0 and four zeros.
// - Mode bit clear selects 12-bit, set selects 8-bit.
// - Power-down bits select state entered after the command.
`timescale 1ns/1ns
`include "tsc_defs.svh"
module tsc_ctrl
(
    input wire logic mclk,
    input wire logic rst,
    // Bus pins
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    // Address strap and panel
    input wire logic [6:0] dev_addr,
    input wire logic touch_detect,
    input wire logic [11:0] adc_code,
    // Status
    output logic pen_touch_irq_n,
    output logic hs_mode,
    output logic conv_busy,
    output tsc_pkg::tsc_cmd_t cur_cmd
);
    import tsc_pkg::*;

    logic [2:0] scl_s_q;
    logic [2:0] sda_s_q;
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
        end
        else
        begin
            scl_s_q <= {scl_s_q[1:0], scl_i};
            sda_s_q <= {sda_s_q[1:0], sda_i};
        end
    end
    wire scl = scl_s_q[1];
    wire sda = sda_s_q[1];
    wire scl_rise = scl_s_q[1] & ~scl_s_q[2];
    wire scl_fall = ~scl_s_q[1] & scl_s_q[2];
    wire start_c = scl && scl_s_q[2] && !sda && sda_s_q[2];
    wire stop_c = scl && scl_s_q[2] && sda && !sda_s_q[2];

    tsc_state_t state_q;
    logic [7:0] sh_q;
    logic [3:0] bit_q;
    logic rw_q;
    logic cmd_seen_q;
    logic hs_q;
    logic sda_low_q;
    logic [7:0] tx_q;
    logic byte_q;
    logic [11:0] res_q;
    logic res_valid_q;
    logic [8:0] cnt_q;
    logic busy_q;
    logic wr_hold_q;
    logic stretch;

    function automatic logic is_driver_only(input logic [3:0] c);
        is_driver_only = (c[3:2] == 2'b10) && (c[1:0] != 2'b11);
    endfunction
    function automatic logic is_measure(input logic [3:0] c);
        is_measure = (c[3:2] == 2'b11);
    endfunction

    wire byte_done = scl_rise && (bit_q == 4'h7);
    wire [7:0] sh_next = {sh_q[6:0], sda};

    // Bit and byte sequencing
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            sh_q <= 8'h00;
            bit_q <= 4'h0;
            rw_q <= 1'b0;
            byte_q <= 1'b0;
        end
        else if (start_c)
        begin
            state_q <= ST_ADDR;
            bit_q <= 4'h0;
        end
        else if (stop_c)
        begin
            state_q <= ST_IDLE;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                    state_q <= ST_IDLE;
                ST_ADDR:
                    if (scl_rise)
                    begin
                        sh_q <= sh_next;
                        bit_q <= (bit_q == 4'h7) ? 4'h0 : bit_q + 4'h1;
                        if (bit_q == 4'h7)
                        begin
                            rw_q <= sda;
                            byte_q <= 1'b0;
                            // High-speed code left unacknowledged
                            if (sh_next[7:3] == `TSC_HS_CODE)
                                state_q <= ST_IDLE;
                            else if (sh_next[7:1] == dev_addr)
                                state_q <= ST_AACK;
                            else
                                state_q <= ST_IDLE;
                        end
                    end
                ST_AACK:
                    if (scl_fall && bit_q == 4'h8)
                    begin
                        bit_q <= 4'h0;
                        state_q <= rw_q ? ST_TX : ST_CMD;
                    end
                    else if (scl_fall)
                        bit_q <= 4'h8;
                ST_CMD:
                    if (scl_rise)
                    begin
                        sh_q <= sh_next;
                        bit_q <= (bit_q == 4'h7) ? 4'h0 : bit_q + 4'h1;
                        if (bit_q == 4'h7)
                            state_q <= cmd_seen_q ? ST_IDLE : ST_CACK;
                    end
                ST_CACK:
                    if (scl_fall && bit_q == 4'h8)
                    begin
                        bit_q <= 4'h0;
                        state_q <= ST_CMD;
                    end
                    else if (scl_fall)
                        bit_q <= 4'h8;
                ST_TX:
                    if (scl_rise)
                    begin
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'h7)
                            state_q <= ST_MACK;
                    end
                ST_MACK:
                    if (scl_rise)
                    begin
                        bit_q <= 4'h0;
                        byte_q <= ~byte_q;
                        state_q <= sda ? ST_IDLE : ST_TX;
                    end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // High-speed mode tracking
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            hs_q <= 1'b0;
        else if (stop_c)
            hs_q <= 1'b0;
        else if (state_q == ST_ADDR && byte_done && sh_next[7:3] == `TSC_HS_CODE)
            hs_q <= 1'b1;
    end

    // Command capture; later bytes before Stop/Start are not acked
    logic [7:0] cmd_raw_q;
    logic cmd_pend_q;
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cmd_raw_q <= 8'h00;
            cmd_seen_q <= 1'b0;
            cmd_pend_q <= 1'b0;
        end
        else if (start_c || stop_c)
        begin
            cmd_seen_q <= 1'b0;
            cmd_pend_q <= 1'b0;
        end
        else if (state_q == ST_CMD && byte_done && !cmd_seen_q)
        begin
            cmd_raw_q <= sh_next;
            cmd_seen_q <= 1'b1;
            cmd_pend_q <= 1'b1;
        end
    end

    // Power-down and mode bits take effect at terminating Stop/Start
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            cur_cmd <= '0;
        else if ((start_c || stop_c) && cmd_pend_q)
        begin
            cur_cmd.input_config_code <= cmd_raw_q[7:`TSC_CMD_CFG_LSB];
            cur_cmd.refer_powerdown_bit <= cmd_raw_q[`TSC_CMD_PD1_BIT];
            cur_cmd.driver_powerdown_bit <= cmd_raw_q[`TSC_CMD_PD0_BIT];
            cur_cmd.mode_8bit <= cmd_raw_q[`TSC_CMD_MODE_BIT];
        end
    end

    // Conversion timing, 8-bit shorter
    wire conv_go = (start_c || stop_c) && cmd_pend_q;
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= 9'h000;
            busy_q <= 1'b0;
        end
        else if (conv_go)
        begin
            busy_q <= 1'b1;
            cnt_q <= cmd_raw_q[`TSC_CMD_MODE_BIT] ? 9'(`TSC_CONV8_CYC - 1) :
                9'(`TSC_CONV12_CYC - 1);
        end
        else if (busy_q)
        begin
            if (cnt_q == 9'h000)
                busy_q <= 1'b0;
            else
                cnt_q <= cnt_q - 9'h001;
        end
    end
    wire conv_end = busy_q && (cnt_q == 9'h000);

    // Result latch; straight binary, 8-bit keeps top bits
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            res_q <= 12'h000;
            res_valid_q <= 1'b0;
        end
        else if (conv_go)
            res_valid_q <= 1'b0;
        else if (conv_end)
        begin
            res_q <= cur_cmd.mode_8bit ? {adc_code[11:4], 4'h0} : adc_code;
            res_valid_q <= 1'b1;
        end
    end

    // Transmit shifter
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            tx_q <= 8'h00;
        else if ((state_q == ST_AACK && rw_q) || (state_q == ST_MACK))
            tx_q <= (cur_cmd.mode_8bit || state_q == ST_AACK || byte_q) ?
                res_q[11:4] : {res_q[3:0], 4'h0};
        else if (state_q == ST_TX && stretch && conv_end)
            tx_q <= adc_code[11:4];
        else if (state_q == ST_TX && scl_fall && bit_q != 4'h0)
            tx_q <= {tx_q[6:0], 1'b0};
    end

    // Stretch SCL low while result pending on a read
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            stretch <= 1'b0;
        else if (state_q == ST_TX && bit_q == 4'h0 && !byte_q && !res_valid_q && !scl)
            stretch <= 1'b1;
        else if (res_valid_q || state_q != ST_TX)
            stretch <= 1'b0;
    end

    // SDA drive
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            sda_low_q <= 1'b0;
        else if (state_q == ST_AACK || state_q == ST_CACK)
            sda_low_q <= (bit_q == 4'h8) || !scl;
        else if (state_q == ST_TX)
            sda_low_q <= !tx_q[7];
        else if (state_q == ST_MACK)
            sda_low_q <= sda_low_q && scl; // Last bit held until SCL falls
        else
            sda_low_q <= 1'b0;
    end

    // Pen detection enable
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            wr_hold_q <= 1'b0;
        else if (state_q == ST_AACK && !rw_q)
            wr_hold_q <= 1'b1;
        else if (conv_end)
            wr_hold_q <= 1'b0;
    end
    wire pen_path = !wr_hold_q && !cur_cmd.driver_powerdown_bit
        && !(busy_q && is_measure(cur_cmd.input_config_code));
    wire force_low = is_driver_only(cur_cmd.input_config_code);
    logic pen_q;
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            pen_q <= 1'b1;
        else
            pen_q <= force_low ? 1'b0 : !(pen_path && touch_detect);
    end

    assign pen_touch_irq_n = pen_q;
    assign scl_o = 1'b0;
    assign scl_oe_n = !stretch;
    assign sda_o = 1'b0;
    assign sda_oe_n = !sda_low_q;
    assign hs_mode = hs_q;
    assign conv_busy = busy_q;

    sequence s_hold;
        wr_hold_q && !conv_end;
    endsequence
    chk_hs_stop_exit: assert property (@(posedge mclk) disable iff (rst)
        stop_c |=> !hs_q) else $error("hs mode kept after stop");
    chk_stretch_release: assert property (@(posedge mclk) disable iff (rst)
        stretch && res_valid_q |=> !stretch) else $error("scl not released");
    chk_pen_hold: assert property (@(posedge mclk) disable iff (rst)
        s_hold && !force_low |=> pen_q) else $error("pen active in hold");
    chk_force_low: assert property (@(posedge mclk) disable iff (rst)
        force_low |=> !pen_q) else $error("pen not forced low");
    chk_pd0_block: assert property (@(posedge mclk) disable iff (rst)
        cur_cmd.driver_powerdown_bit && !force_low |=> pen_q) else $error("pen active pd0");
    chk_conv8_len: assert property (@(posedge mclk) disable iff (rst)
        conv_go && cmd_raw_q[`TSC_CMD_MODE_BIT] |=> busy_q [*8]) else $error("short conv");
    chk_wr_ack_dis: assert property (@(posedge mclk) disable iff (rst)
        state_q == ST_AACK && !rw_q |=> wr_hold_q) else $error("pen not disabled");
    chk_hs_no_ack: assert property (@(posedge mclk) disable iff (rst)
        state_q == ST_ADDR && byte_done && sh_next[7:3] == `TSC_HS_CODE
        |=> state_q == ST_IDLE && hs_q) else $error("hs code acked");
    chk_arm_touch: assert property (@(posedge mclk) disable iff (rst)
        pen_path && touch_detect && !force_low |=> !pen_q) else $error("touch missed");
endmodule

//--- sim/tsc_mst.sv
`timescale 1ns/1ns
module tsc_mst
(
    // Clock
    input wire logic mclk,
    // Resolved bus levels
    input wire logic scl_w,
    input wire logic sda_w,
    // Open-drain drive, 0 pulls low
    output logic scl_m,
    output logic sda_m
);
    int stalls = 0;
    initial
    begin
        scl_m = 1'b1;
        sda_m = 1'b1;
    end
    task automatic hp();
        repeat (4) @(posedge mclk);
    endtask
    // Start, also repeated Start between transfers
    task automatic start();
        sda_m <= 1'b1;
        hp();
        scl_m <= 1'b1;
        hp();
        sda_m <= 1'b0;
        hp();
        scl_m <= 1'b0;
        hp();
    endtask
    task automatic stop();
        sda_m <= 1'b0;
        hp();
        scl_m <= 1'b1;
        hp();
        sda_m <= 1'b1;
        hp();
    endtask
    // One bit, waits out clock stretching
    task automatic bit_io(input logic b, output logic r);
        int n;
        n = 0;
        sda_m <= b;
        hp();
        scl_m <= 1'b1;
        hp();
        while (scl_w !== 1'b1 && n < 2000)
        begin
            @(posedge mclk);
            n++;
        end
        if (n >= 2000)
            stalls++;
        hp();
        r = sda_w;
        scl_m <= 1'b0;
        hp();
    endtask
    // Byte plus acknowledge bit, MSB first
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(a, k);
    endtask
endmodule

//--- sim/test_tsc_ctrl.sv
`timescale 1ns/1ns
module test_tsc_ctrl;
    import tsc_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic touch_detect = 1'b0;
    logic [11:0] adc_code = 12'h000;
    logic [6:0] dev_addr = 7'h48;
    logic scl_m, sda_m, scl_o, scl_oe_n, sda_o, sda_oe_n;
    logic pen_touch_irq_n, hs_mode, conv_busy;
    logic saw_stretch = 1'b0;
    tsc_cmd_t cur_cmd;
    wire scl_w = scl_m & (scl_oe_n | scl_o);
    wire sda_w = sda_m & (sda_oe_n | sda_o);
    int fails = 0;
    int checked = 0;
    always #20 mclk = ~mclk;
    tsc_mst tsc_mst_inst (.mclk(mclk), .scl_w(scl_w), .sda_w(sda_w), .scl_m(scl_m),
        .sda_m(sda_m));
    tsc_ctrl tsc_ctrl_inst (.mclk(mclk), .rst(rst), .scl_i(scl_w), .scl_o(scl_o),
        .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .dev_addr(dev_addr), .touch_detect(touch_detect), .adc_code(adc_code),
        .pen_touch_irq_n(pen_touch_irq_n), .hs_mode(hs_mode), .conv_busy(conv_busy),
        .cur_cmd(cur_cmd));
    always @(posedge mclk)
    begin
        if (scl_oe_n === 1'b0 && scl_m === 1'b1)
            saw_stretch <= 1'b1;
        if (tsc_mst_inst.stalls != 0)
        begin
            fails++;
            end_of_test();
        end
    end
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Address write, one command byte, Stop; checks pen held high after address ack if chk_pen
    task automatic wr(input logic [7:0] cmd, input logic chk_pen);
        logic [7:0] q;
        logic k;
        tsc_mst_inst.start();
        tsc_mst_inst.xfer({dev_addr, 1'b0}, 1'b1, q, k);
        check(k, 1'b0);
        if (chk_pen)
            check(pen_touch_irq_n, 1'b1);
        tsc_mst_inst.xfer(cmd, 1'b1, q, k);
        check(k, 1'b0);
        tsc_mst_inst.stop();
    endtask
    // Address read, two bytes, master acks the first only
    task automatic rd(output logic [7:0] b1, output logic [7:0] b2);
        logic [7:0] q;
        logic k;
        tsc_mst_inst.start();
        tsc_mst_inst.xfer({dev_addr, 1'b1}, 1'b1, q, k);
        check(k, 1'b0);
        tsc_mst_inst.xfer(8'hFF, 1'b0, b1, k);
        tsc_mst_inst.xfer(8'hFF, 1'b1, b2, k);
        tsc_mst_inst.stop();
    endtask
    task automatic wait_conv(output int n);
        n = 0;
        while (conv_busy === 1'b1 && n < 2000)
        begin
            @(posedge mclk);
            n++;
        end
        if (n >= 2000)
        begin
            fails++;
            end_of_test();
        end
        repeat (3) @(posedge mclk);
    endtask
    task automatic s_hs();
        logic [7:0] q;
        logic k;
        tsc_mst_inst.start();
        tsc_mst_inst.xfer(8'h0D, 1'b1, q, k);
        check(k, 1'b1);
        check(hs_mode, 1'b1);
        tsc_mst_inst.start();
        tsc_mst_inst.start();
        check(hs_mode, 1'b1);
        tsc_mst_inst.stop();
        repeat (4) @(posedge mclk);
        check(hs_mode, 1'b0);
    endtask
    task automatic s_conv12();
        int n;
        logic [7:0] b1, b2;
        touch_detect <= 1'b1;
        adc_code <= 12'hA5C;
        wr(8'h00, 1'b1);
        check(cur_cmd, 12'h000);
        check(conv_busy, 1'b1);
        check(pen_touch_irq_n, 1'b1);
        wait_conv(n);
        check(n >= 230 && n <= 255, 1'b1);
        check(pen_touch_irq_n, 1'b0);
        rd(b1, b2);
        check(b1, 8'hA5);
        check(b2, 8'hC0);
    endtask
    task automatic s_conv8();
        int n;
        logic [7:0] b1, b2;
        wr(8'h02, 1'b1);
        check(cur_cmd.mode_8bit, 1'b1);
        wait_conv(n);
        check(n >= 155 && n <= 180, 1'b1);
        adc_code <= 12'h3C7;
        wr(8'h02, 1'b1);
        rd(b1, b2);
        check(saw_stretch, 1'b1);
        check(b1, 8'h3C);
        check(b2, 8'h3C);
    endtask
    task automatic s_pd();
        int n;
        wr(8'h04, 1'b1);
        wait_conv(n);
        check(pen_touch_irq_n, 1'b1);
        wr(8'h00, 1'b1);
        wait_conv(n);
        check(pen_touch_irq_n, 1'b0);
    endtask
    task automatic s_drv();
        int n;
        touch_detect <= 1'b0;
        wr(8'h80, 1'b1);
        wait_conv(n);
        check(pen_touch_irq_n, 1'b0);
        touch_detect <= 1'b1;
        wr(8'hC0, 1'b0);
        repeat (2) @(posedge mclk);
        check(pen_touch_irq_n, 1'b1);
        wait_conv(n);
        check(pen_touch_irq_n, 1'b0);
    endtask
    initial
    begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        s_hs();
        s_conv12();
        s_conv8();
        s_pd();
        s_drv();
        end_of_test();
    end
endmodule
